// ===== src/bwt_bridge_xlate.sv
// Summary of operation
// R1: no PCI transaction starts until the PCI core reports it is configured.
// R2: arbiter holds grant two consecutive PCI clocks before the bridge starts.
// R3: up to six local-bus windows map to PCI, each with own settings.
// R4: up to three PCI base windows map to local bus, power-of-two length.
// R5: inbound windows claim PCI memory space only, never I/O.
// R6: outbound replaces the leading bits that base and high address share.
// R7: inbound replaces bus width minus length exponent high bits.
// R8: all bits below the replaced field pass through unchanged.
// R9: build option picks outbound vector from parameter or per-window register.
// R10: inbound vector comes only from a build-time parameter.
// R11: translation exists only in builds with data FIFOs.
// R12: outbound ignores inbound settings and inbound ignores outbound settings.
// R13: translation vector bits below the replaced field are ignored.
// R14: address hits a window when its replaced field equals the base.
// R15: outbound window count one to six, window 0 always present.
// R16: space type 0 selects I/O, 1 memory; memory is default.
// R17: I/O commands only for accesses hitting an I/O-designated window.
//
// Implementation choices: the plain strobed port and the placing of the registers.
module bwt_bridge_xlate #(
   parameter int                         outbound_window_count        = bwt_pkg::OUT_WIN_MAX,
   parameter int                         inbound_window_count         = bwt_pkg::IN_WIN_MAX,
   parameter bit                         include_fifos                = 1'b1,
   parameter bit                         use_runtime_offset_register  = 1'b0,
   parameter logic [5:0][31:0]           outbound_window_base         = {6{bwt_pkg::OUT_BASE_RST}},
   parameter logic [5:0][31:0]           outbound_window_high         = {6{bwt_pkg::OUT_HIGH_RST}},
   parameter logic [5:0][31:0]           outbound_translation_vector  = {6{bwt_pkg::OUT_VEC_RST}},
   parameter logic [5:0]                 outbound_window_space_type   = {6{bwt_pkg::OUT_SPACE_MEM}},
   parameter int                         inbound_window_length_exponent [3] =
                                            '{bwt_pkg::IN_LEN_RST, bwt_pkg::IN_LEN_RST,
                                              bwt_pkg::IN_LEN_RST},
   parameter logic [2:0][31:0]           inbound_translation_vector   = {3{bwt_pkg::IN_VEC_RST}}
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // PCI core state and arbiter pin
   input  wire logic        cfg_done,
   input  wire logic        gnt_n,
   // outbound: local-bus master request
   input  wire logic        lb_req,
   input  wire logic [31:0] lb_addr,
   output logic             lb_miss,
   output logic             pci_req_n,
   output logic             pci_start,
   output logic [31:0]      pci_addr,
   output logic             pci_io,
   // inbound: PCI initiator address phase
   input  wire logic        pci_in_req,
   input  wire logic [31:0] pci_in_addr,
   input  wire logic        pci_in_is_io,
   output logic             lb_out_valid,
   output logic [31:0]      lb_out_addr,
   output logic [1:0]       lb_out_win,
   output logic             pci_in_claim
);
   // build sanity
   if (outbound_window_count < 1 || outbound_window_count > bwt_pkg::OUT_WIN_MAX) begin : g_chk_out
      $error("outbound window count must be 1 to 6"); // R15
   end
   if (inbound_window_count < 1 || inbound_window_count > bwt_pkg::IN_WIN_MAX) begin : g_chk_in
      $error("inbound window count must be 1 to 3");
   end
   for (genvar c = 0; c < bwt_pkg::IN_WIN_MAX; c++) begin : g_chk_len
      if (inbound_window_length_exponent[c] < 1 ||
          inbound_window_length_exponent[c] > bwt_pkg::ADDR_W) begin : g_bad
         $error("inbound length exponent out of range");
      end
   end

   bwt_pkg::bwt_state_t st;
   logic [5:0][31:0]    out_vec_reg;
   logic [2:0][31:0]    in_base_reg;
   logic [31:0]         control;
   logic                gnt_meta;
   logic                gnt_low_s;
   logic                gnt_cnt;
   logic [2:0]          out_win;
   logic [31:0]         lb_addr_q;
   logic [31:0]         in_addr_q;
   logic [5:0]          out_hit;
   logic [5:0][31:0]    out_x;
   logic [5:0][31:0]    out_vec;
   logic [5:0][31:0]    out_mask;
   logic [2:0]          in_hit;
   logic [2:0][31:0]    in_x;
   logic [2:0][31:0]    in_mask;
   logic                out_any;
   logic [2:0]          out_sel;
   logic                in_any;
   logic [1:0]          in_sel;
   logic                out_ok;

   // outbound windows see only outbound settings
   for (genvar n = 0; n < bwt_pkg::OUT_WIN_MAX; n++) begin : g_out
      assign out_mask[n] = bwt_pkg::bwt_common_mask(outbound_window_base[n],
                                                     outbound_window_high[n]); // R6
      assign out_vec[n]  = use_runtime_offset_register ? out_vec_reg[n]
                                                       : outbound_translation_vector[n]; // R9
      bwt_window #(
         .MASK    (bwt_pkg::bwt_common_mask(outbound_window_base[n],
                                            outbound_window_high[n])),
         .PRESENT (n < outbound_window_count) // R3 R15
      ) u_win (
         .addr  (lb_addr),
         .base  (outbound_window_base[n]),
         .vec   (out_vec[n]),
         .hit   (out_hit[n]),
         .xaddr (out_x[n])
      ); // R12
   end

   // inbound windows see only inbound settings; vector fixed at build
   for (genvar m = 0; m < bwt_pkg::IN_WIN_MAX; m++) begin : g_in
      assign in_mask[m] = bwt_pkg::bwt_len_mask(inbound_window_length_exponent[m]); // R7
      bwt_window #(
         .MASK    (bwt_pkg::bwt_len_mask(inbound_window_length_exponent[m])),
         .PRESENT (m < inbound_window_count) // R4
      ) u_win (
         .addr  (pci_in_addr),
         .base  (in_base_reg[m]),
         .vec   (inbound_translation_vector[m]), // R10
         .hit   (in_hit[m]),
         .xaddr (in_x[m])
      ); // R12
   end

   // lowest index wins where windows overlap
   always_comb begin
      out_any = 1'b0;
      out_sel = 3'h0;
      for (int i = bwt_pkg::OUT_WIN_MAX - 1; i >= 0; i--) begin
         if (out_hit[i]) begin
            out_any = 1'b1;
            out_sel = 3'(i);
         end
      end
   end

   always_comb begin
      in_any = 1'b0;
      in_sel = 2'h0;
      for (int i = bwt_pkg::IN_WIN_MAX - 1; i >= 0; i--) begin
         if (in_hit[i]) begin
            in_any = 1'b1;
            in_sel = 2'(i);
         end
      end
   end

   // grant is a pin: two flops before anyone looks at it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gnt_meta  <= 1'b0;
         gnt_low_s <= 1'b0;
      end else begin
         gnt_meta  <= ~gnt_n;
         gnt_low_s <= gnt_meta;
      end
   end

   // a request is accepted only when configured and software enabled
   assign out_ok = cfg_done && control[bwt_pkg::CONTROL_EN_BIT]; // R1

   // outbound sequencer: capture, request bus, start after held grant
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st        <= bwt_pkg::BWT_IDLE;
         gnt_cnt   <= 1'b0;
         pci_req_n <= 1'b1;
         pci_start <= 1'b0;
         lb_miss   <= 1'b0;
         pci_addr  <= 32'h00000000;
         pci_io    <= 1'b0;
         out_win   <= 3'h0;
         lb_addr_q <= 32'h00000000;
      end else begin
         pci_start <= 1'b0;
         lb_miss   <= 1'b0;
         case (st)
            bwt_pkg::BWT_IDLE: begin
               gnt_cnt <= 1'b0;
               if (lb_req) begin
                  if (!include_fifos && out_ok) begin
                     // no FIFO build: address goes through untouched
                     pci_addr  <= lb_addr; // R11
                     pci_io    <= 1'b0;
                     out_win   <= 3'h0;
                     lb_addr_q <= lb_addr;
                     pci_req_n <= 1'b0;
                     st        <= bwt_pkg::BWT_WAIT_GNT;
                  end else if (out_any && out_ok) begin
                     pci_addr  <= out_x[out_sel]; // R6 R8
                     pci_io    <= ~outbound_window_space_type[out_sel]; // R16 R17
                     out_win   <= out_sel;
                     lb_addr_q <= lb_addr;
                     pci_req_n <= 1'b0;
                     st        <= bwt_pkg::BWT_WAIT_GNT;
                  end else begin
                     lb_miss <= 1'b1;
                  end
               end
            end
            bwt_pkg::BWT_WAIT_GNT: begin
               if (!cfg_done) begin
                  // core lost its configuration: drop the request
                  pci_req_n <= 1'b1;
                  st        <= bwt_pkg::BWT_IDLE; // R1
               end else if (gnt_low_s && gnt_cnt) begin
                  // second consecutive grant sample
                  pci_start <= 1'b1; // R2
                  pci_req_n <= 1'b1;
                  gnt_cnt   <= 1'b0;
                  st        <= bwt_pkg::BWT_IDLE;
               end else begin
                  gnt_cnt <= gnt_low_s; // R2
               end
            end
            default: begin
               st        <= bwt_pkg::BWT_IDLE;
               pci_req_n <= 1'b1;
            end
         endcase
      end
   end

   // inbound: claim memory accesses that hit a window, one cycle later
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lb_out_valid <= 1'b0;
         lb_out_addr  <= 32'h00000000;
         lb_out_win   <= 2'h0;
         pci_in_claim <= 1'b0;
         in_addr_q    <= 32'h00000000;
      end else begin
         lb_out_valid <= 1'b0;
         pci_in_claim <= 1'b0;
         if (pci_in_req && !pci_in_is_io && in_any) begin // R5
            lb_out_valid <= 1'b1;
            pci_in_claim <= 1'b1;
            lb_out_addr  <= include_fifos ? in_x[in_sel] : pci_in_addr; // R7 R8 R11
            lb_out_win   <= in_sel;
            in_addr_q    <= pci_in_addr;
         end
      end
   end

   // register writes; control and vectors steer translation
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         control     <= bwt_pkg::CONTROL_RST;
         out_vec_reg <= {6{bwt_pkg::OUT_VEC_RST}};
         in_base_reg <= {3{bwt_pkg::IN_BASE_RST}};
      end else if (reg_wr) begin
         if (reg_addr == bwt_pkg::REG_CONTROL) begin
            control <= {31'h00000000, reg_wdata[bwt_pkg::CONTROL_EN_BIT]};
         end
         for (int i = 0; i < bwt_pkg::OUT_WIN_MAX; i++) begin
            if (reg_addr == bwt_pkg::REG_OUT_VEC0 + 8'(4 * i)) begin
               out_vec_reg[i] <= reg_wdata; // R9
            end
         end
         // host-assigned bases, written by the configuration path
         for (int i = 0; i < bwt_pkg::IN_WIN_MAX; i++) begin
            if (reg_addr == bwt_pkg::REG_IN_BASE0 + 8'(4 * i)) begin
               in_base_reg[i] <= reg_wdata; // R14
            end
         end
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            if (reg_addr == bwt_pkg::REG_STATUS) begin
               reg_rdata[bwt_pkg::STATUS_CFG_BIT]  <= cfg_done;
               reg_rdata[bwt_pkg::STATUS_BUSY_BIT] <= (st == bwt_pkg::BWT_WAIT_GNT);
               reg_rdata[bwt_pkg::STATUS_GNT_BIT]  <= gnt_low_s;
            end
            if (reg_addr == bwt_pkg::REG_CONTROL) begin
               reg_rdata <= control;
            end
            for (int i = 0; i < bwt_pkg::OUT_WIN_MAX; i++) begin
               if (reg_addr == bwt_pkg::REG_OUT_VEC0 + 8'(4 * i)) begin
                  reg_rdata <= out_vec_reg[i];
               end
            end
            for (int i = 0; i < bwt_pkg::IN_WIN_MAX; i++) begin
               if (reg_addr == bwt_pkg::REG_IN_BASE0 + 8'(4 * i)) begin
                  reg_rdata <= in_base_reg[i];
               end
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_held_grant;
      (st == bwt_pkg::BWT_WAIT_GNT && gnt_low_s && cfg_done)[*2];
   endsequence

   AST_NO_START_UNCONF: assert property (pci_start |-> $past(cfg_done)) // R1
      else $error("start issued while core not configured");
   AST_GNT_TWO: assert property (pci_start |-> $past(gnt_low_s, 1) && $past(gnt_low_s, 2)) // R2
      else $error("start without two grant cycles");
   AST_START_SEQ: assert property (s_held_grant |=> pci_start) // R2
      else $error("held grant did not start transaction");
   AST_LOW_BITS: assert property (!pci_req_n && include_fifos |->
                  ((pci_addr ^ lb_addr_q) & ~out_mask[out_win]) == 32'h00000000) // R8
      else $error("outbound low bits altered");
   AST_HIGH_BITS: assert property (!pci_req_n && include_fifos |->
                  ((pci_addr ^ out_vec[out_win]) & out_mask[out_win]) == 32'h00000000) // R6
      else $error("outbound high field not from vector");
   AST_IO_ONLY: assert property (pci_start && include_fifos |->
                  pci_io == !outbound_window_space_type[out_win]) // R17
      else $error("I/O command on memory window");
   AST_IN_NO_IO: assert property (lb_out_valid |-> !$past(pci_in_is_io)) // R5
      else $error("inbound I/O access claimed");
   AST_IN_LEN: assert property (lb_out_valid && include_fifos |->
                  ((lb_out_addr ^ in_addr_q) & ~in_mask[lb_out_win]) == 32'h00000000) // R7
      else $error("inbound low bits altered");
   AST_MISS: assert property (st == bwt_pkg::BWT_IDLE && lb_req && !out_ok |=>
                  lb_miss && pci_req_n) // R1
      else $error("refused request not flagged");
   AST_IN_IO_REFUSE: assert property (pci_in_req && pci_in_is_io |=> !pci_in_claim && !lb_out_valid) // R5
      else $error("inbound I/O access not refused");
   AST_IN_WIN_USED: assert property (lb_out_valid |-> lb_out_win < inbound_window_count) // R4
      else $error("claim on an absent inbound window");
   AST_REQ_HOLD: assert property (!pci_req_n && cfg_done |=> !pci_req_n || pci_start) // R2
      else $error("request withdrawn without start");
endmodule : bwt_bridge_xlate

// ===== src/bwt_pkg.sv
package bwt_pkg;
   // bus and window geometry
   localparam int          ADDR_W            = 32;
   localparam int          OUT_WIN_MAX       = 6;
   localparam int          IN_WIN_MAX        = 3;
   localparam int          REG_ADDR_W        = 8;
   localparam int          GNT_HOLD_CYCLES   = 2;

   // register offsets (byte addresses)
   localparam logic [7:0]  REG_STATUS        = 8'h00;
   localparam logic [7:0]  REG_CONTROL       = 8'h04;
   localparam logic [7:0]  REG_OUT_VEC0      = 8'h10;
   localparam logic [7:0]  REG_IN_BASE0      = 8'h30;

   // field positions
   localparam int          STATUS_CFG_BIT    = 0;
   localparam int          STATUS_BUSY_BIT   = 1;
   localparam int          STATUS_GNT_BIT    = 2;
   localparam int          CONTROL_EN_BIT    = 0;

   // reset and default values
   localparam logic [31:0] OUT_BASE_RST      = 32'hFFFFFFFF;
   localparam logic [31:0] OUT_HIGH_RST      = 32'h00000000;
   localparam logic [31:0] OUT_VEC_RST       = 32'hFFFFFFFF;
   localparam logic        OUT_SPACE_MEM     = 1'h1;
   localparam logic [31:0] IN_VEC_RST        = 32'hFFFFFFFF;
   localparam logic [31:0] IN_BASE_RST       = 32'h00000000;
   localparam int          IN_LEN_RST        = 16;
   localparam logic [31:0] CONTROL_RST       = 32'h00000001;

   // outbound sequencer states
   typedef enum logic [0:0] {
      BWT_IDLE     = 1'b0,
      BWT_WAIT_GNT = 1'b1
   } bwt_state_t;

   // mask of the leading bits that base and high address share
   function automatic logic [31:0] bwt_common_mask(input logic [31:0] base,
                                                   input logic [31:0] high);
      logic [31:0] m;
      logic        same;
      m    = 32'h00000000;
      same = 1'b1;
      for (int i = 31; i >= 0; i--) begin
         same = same && (base[i] == high[i]);
         m[i] = same;
      end
      return m;
   endfunction : bwt_common_mask

   // mask of the bits above a 2**len window
   function automatic logic [31:0] bwt_len_mask(input int len);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 32; i++) begin
         m[i] = (i >= len);
      end
      return m;
   endfunction : bwt_len_mask
endpackage : bwt_pkg

// ===== src/bwt_window.sv
// one window: match on the replaced field, substitute it, pass the rest
module bwt_window #(
   parameter logic [31:0] MASK    = 32'h00000000,
   parameter bit          PRESENT = 1'b1
) (
   input  wire logic [31:0] addr,
   input  wire logic [31:0] base,
   input  wire logic [31:0] vec,
   output logic             hit,
   output logic [31:0]      xaddr
);
   // match only on the replaced high field
   assign hit   = PRESENT && (((addr ^ base) & MASK) == 32'h00000000); // R14
   // vector bits under the field are dropped, address bits under it kept
   assign xaddr = (vec & MASK) | (addr & ~MASK); // R8 R13
endmodule : bwt_window

// ===== tb/bwt_arb_model.sv
// arbiter beside the bridge: grants after a chosen delay, or only briefly
module bwt_arb_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       pci_req_n,
   input  wire logic [3:0] gnt_delay,
   input  wire logic       short_gnt,
   output logic            gnt_n
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] wait_cnt;

   // grant is withdrawn as soon as the request goes away
   always_ff @(posedge sys_clk) begin
      if (!rst_n || pci_req_n) begin
         wait_cnt <= 4'h0;
         gnt_n    <= 1'h1;
      end else begin
         wait_cnt <= (wait_cnt == 4'hF) ? 4'hF : wait_cnt + 4'h1;
         // short mode toggles, so two low samples in a row never occur
         if (short_gnt) begin
            gnt_n <= ~gnt_n;
         end else begin
            gnt_n <= (wait_cnt < gnt_delay);
         end
      end
   end
endmodule : bwt_arb_model

// ===== tb/bwt_bridge_xlate_tb.sv
module bwt_bridge_xlate_tb;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [31:0] OB_IN  [4] = '{32'h12340ABC, 32'hABCDF123, 32'hFFFEDCBA, 32'h00000071};
   localparam logic [31:0] OB_OUT [4] = '{32'h56710ABC, 32'hFEDC1123, 32'h41FEDCBA, 32'h876543F1};
   localparam logic [31:0] OB_RT  [4] = '{32'h9ABC0ABC, 32'hFFFFF123, 32'hFFFEDCBA, 32'hFFFFFFF1};
   localparam logic [3:0]  OB_IO      = 4'h8;

   logic        sys_clk, rst_n, reg_wr, reg_rd, cfg_done, gnt_n, lb_req, lb_miss;
   logic        pci_req_n, pci_start, pci_io, pci_in_req, pci_in_is_io, lb_out_valid;
   logic        pci_in_claim, short_gnt, rd_seen;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, lb_addr, pci_addr, pci_in_addr, lb_out_addr, r, exp_r;
   logic [31:0] pci_addr_rt, exp_t;
   logic [31:0] rt_q[$];
   logic [1:0]  lb_out_win;
   logic [3:0]  gnt_delay;
   logic [33:0] exp_o, exp_i;
   logic [33:0] out_q[$];
   logic [33:0] in_q[$];
   logic [31:0] rd_exp[$];
   int          fail_count, checks;

   localparam logic [5:0][31:0] P_BASE = {32'h20000000, 32'h20000000, 32'h00000000,
                                          32'hFE000000, 32'hABCDE000, 32'h12340000};
   localparam logic [5:0][31:0] P_HIGH = {32'h2000FFFF, 32'h2000FFFF, 32'h0000007F,
                                          32'hFFFFFFFF, 32'hABCDFFFF, 32'h1234FFFF};
   localparam logic [5:0][31:0] P_VEC  = {32'hFFFFFFFF, 32'hFFFFFFFF, 32'h876543FF,
                                          32'h41FFFFFF, 32'hFEDC1FFF, 32'h5671FFFF};
   localparam int               P_LEN [3] = '{11, 25, 16};
   localparam logic [2:0][31:0] P_IVEC = {32'hFFFFFFFF, 32'hFFFFFFFF, 32'h123457FF};

   bwt_bridge_xlate #(
      .outbound_window_count         (4),
      .inbound_window_count          (2),
      .outbound_window_base          (P_BASE),
      .outbound_window_high          (P_HIGH),
      .outbound_translation_vector   (P_VEC),
      .outbound_window_space_type    (6'h37),
      .inbound_window_length_exponent(P_LEN),
      .inbound_translation_vector    (P_IVEC)
   ) dut (.*);

   // same windows, outbound vectors taken from registers
   bwt_bridge_xlate #(
      .outbound_window_count         (4),
      .inbound_window_count          (2),
      .use_runtime_offset_register   (1'b1),
      .outbound_window_base          (P_BASE),
      .outbound_window_high          (P_HIGH),
      .outbound_translation_vector   (P_VEC),
      .outbound_window_space_type    (6'h37),
      .inbound_window_length_exponent(P_LEN),
      .inbound_translation_vector    (P_IVEC)
   ) dut_rt (.*, .reg_rdata(), .lb_miss(), .pci_req_n(), .pci_start(), .pci_addr(pci_addr_rt),
             .pci_io(), .lb_out_valid(), .lb_out_addr(), .lb_out_win(), .pci_in_claim());

   bwt_arb_model arb (.*);

   // free-running clock, 20 ns period
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   // bounded wait until every noted result has shown up
   task automatic wait_drain();
      for (int i = 0; i < 60; i++) begin
         if (out_q.size() == 0 && in_q.size() == 0 && rd_exp.size() == 0 &&
             rt_q.size() == 0) return;
         @(posedge sys_clk);
      end
      fail_count++;
      $display("Error drain expected empty seen pending");
      end_sim();
   endtask : wait_drain

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      rd_exp.push_back(exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      wait_drain();
   endtask : reg_read

   task automatic out_req(input logic [31:0] a, input logic miss, input logic io,
                          input logic [31:0] exp, input logic [31:0] rt);
      out_q.push_back(miss ? {1'b1, 33'h0} : {1'b0, io, exp});
      if (!miss) rt_q.push_back(rt);
      lb_req  <= 1'b1;
      lb_addr <= a;
      @(posedge sys_clk);
      lb_req  <= 1'b0;
      lb_addr <= ~a; // stale address must not matter once taken
      wait_drain();
   endtask : out_req

   task automatic in_req(input logic [31:0] a, input logic io, input logic hit,
                         input logic [33:0] exp);
      if (hit) in_q.push_back(exp);
      pci_in_req   <= 1'b1;
      pci_in_addr  <= a;
      pci_in_is_io <= io;
      @(posedge sys_clk);
      pci_in_req <= 1'b0;
      repeat (2) @(posedge sys_clk); // room for an unwanted claim to show
      wait_drain();
   endtask : in_req

   // monitor: each result takes the oldest note of its kind
   always @(posedge sys_clk) begin
      rd_seen <= reg_rd;
      if (rst_n && (lb_miss || pci_start)) begin
         exp_o = (out_q.size() > 0) ? out_q.pop_front() : 'x;
         chk("outbound", 40'({lb_miss, lb_miss ? 33'h0 : {pci_io, pci_addr}}), 40'(exp_o));
         if (pci_start) chk("req_release", 40'(pci_req_n), 40'h1);
         if (pci_start) begin
            exp_t = (rt_q.size() > 0) ? rt_q.pop_front() : 'x;
            chk("rt_addr", 40'(pci_addr_rt), 40'(exp_t));
         end
      end
      if (rst_n && (lb_out_valid || pci_in_claim)) begin
         exp_i = (in_q.size() > 0) ? in_q.pop_front() : 'x;
         chk("inbound", 40'({pci_in_claim, lb_out_valid, lb_out_win, lb_out_addr}),
             40'({2'h3, exp_i}));
      end
      if (rst_n && rd_seen) begin
         exp_r = (rd_exp.size() > 0) ? rd_exp.pop_front() : 'x;
         chk("rdata", 40'(reg_rdata), 40'(exp_r));
      end
   end

   initial begin
      {rst_n, reg_wr, reg_rd, cfg_done, lb_req, pci_in_req, pci_in_is_io, short_gnt} = '0;
      {reg_addr, reg_wdata, lb_addr, pci_in_addr, gnt_delay} = '0;
      {fail_count, checks} = '0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      r = $urandom(32'h891D93E4);
      // reset values and an unmapped place
      reg_read(8'h00, 32'h0);
      reg_read(8'h04, 32'h1);
      reg_read(8'h10, 32'hFFFFFFFF);
      reg_read(8'h30, 32'h0);
      reg_read(8'h08, 32'h0);
      out_req(OB_IN[0], 1'b1, 1'b0, 32'h0, 32'h0);
      cfg_done <= 1'b1;
      reg_read(8'h00, 32'h1);
      reg_write(8'h30, 32'hABCDE800);
      reg_write(8'h34, 32'h12000000);
      reg_write(8'h38, 32'h77770000);
      reg_read(8'h34, 32'h12000000);
      reg_write(8'h10, 32'h9ABC0000); // dut keeps parameter vectors, dut_rt uses this one
      reg_read(8'h10, 32'h9ABC0000);
      // outbound windows, slow and prompt grants
      for (int i = 0; i < 4; i++) begin
         gnt_delay <= 4'($urandom_range(0, 9));
         out_req(OB_IN[i], 1'b0, OB_IO[i], OB_OUT[i], OB_RT[i]);
      end
      r = $urandom();
      out_req({16'h1234, r[15:0]}, 1'b0, 1'b0, {16'h5671, r[15:0]}, {16'h9ABC, r[15:0]});
      out_req(32'h20000010, 1'b1, 1'b0, 32'h0, 32'h0);
      out_req(32'h30000000, 1'b1, 1'b0, 32'h0, 32'h0);
      // grant too short: must wait, then drop when configuration is lost
      short_gnt <= 1'b1;
      lb_req    <= 1'b1;
      lb_addr   <= OB_IN[0];
      @(posedge sys_clk);
      lb_req <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk("req_pending", 40'(pci_req_n), 40'h0);
      cfg_done <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("req_dropped", 40'(pci_req_n), 40'h1);
      cfg_done  <= 1'b1;
      short_gnt <= 1'b0;
      reg_write(8'h04, 32'h0);
      out_req(OB_IN[1], 1'b1, 1'b0, 32'h0, 32'h0);
      reg_write(8'h04, 32'h1);
      // inbound windows
      in_req(32'hABCDEFF4, 1'b0, 1'b1, {2'h0, 32'h123457F4});
      in_req(32'h1235FEDC, 1'b0, 1'b1, {2'h1, 32'hFE35FEDC});
      r = $urandom();
      in_req({21'h1579BD, r[10:0]}, 1'b0, 1'b1, {2'h0, 21'h02468A, r[10:0]});
      in_req(32'hABCDEFF4, 1'b1, 1'b0, 34'h0);
      in_req(32'h77770010, 1'b0, 1'b0, 34'h0);
      in_req(32'h55555555, 1'b0, 1'b0, 34'h0);
      end_sim();
   end
endmodule : bwt_bridge_xlate_tb
